// ### tcw_pkg.sv
// package: field layout, codes and constants of the test control word
package tcw_pkg;

   localparam int CMD_W = 40;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CMD_BITS = 6'h28;
   localparam int SYNC_STAGES = 3;

   localparam int ADDR_HI = 39;
   localparam int ADDR_LO = 37;
   localparam int UPDATE_BIT = 36;
   localparam logic [2:0] TEST_WORD_ADDR = 3'h7;

   localparam int RSV_HI = 35;
   localparam int RSV_LO = 14;
   localparam int WORD_W = 14;
   localparam logic [WORD_W-1:0] WORD_RST = 14'h0000;

   localparam int FORCE_DATA_BIT = 13;
   localparam int ACC_HI = 12;
   localparam int ACC_LO = 11;
   localparam int Q_ROLL_BIT = 10;
   localparam int FORCE_OUT_BIT = 9;
   localparam int F_CLK_BIT = 8;
   localparam int F_STB_BIT = 7;
   localparam int F_I_BIT = 6;
   localparam int F_Q_BIT = 5;
   localparam int SINCOS_BYP_BIT = 4;
   localparam int SCALE_BYP_BIT = 3;
   localparam int RSV_BIT = 2;
   localparam int WAIT_RAM_BIT = 1;
   localparam int OVF_DIS_BIT = 0;

   localparam int SAMPLE_W = 16;
   localparam logic [SAMPLE_W-1:0] FORCED_SAMPLE = 16'h8000;
   localparam int COEF_W = 20;
   localparam logic [COEF_W-1:0] UNITY_COEF = 20'hFFFFF;

   typedef enum logic [1:0] {
      ACC_NORMAL = 2'h0,
      ACC_OFF    = 2'h1,
      ACC_CONT   = 2'h2,
      ACC_RSV    = 2'h3
   } tcw_acc_t;

   typedef enum logic [1:0] {
      GATE_WAIT = 2'b01,
      GATE_RUN  = 2'b10
   } tcw_gate_t;

endpackage : tcw_pkg

// ### tcw_cmd_if.sv
// interface: one received 40-bit command, valid for one cycle
`timescale 1ns/1ps
interface tcw_cmd_if;
   import tcw_pkg::*;
   logic              valid;
   logic [CMD_W-1:0]  word;
   modport rx   (output valid, output word);
   modport core (input valid, input word);
endinterface : tcw_cmd_if

// ### tcw_ser_rx.sv
// module: serial control port receiver, pins synchronised, msb first
`timescale 1ns/1ps
module tcw_ser_rx
   import tcw_pkg::*;
(
   input  wire logic  i_clock,
   input  wire logic  i_rst_n,
   input  wire logic  i_ctl_clk,
   input  wire logic  i_ctl_data,
   input  wire logic  i_ctl_sel_n,
   tcw_cmd_if.rx      cmd
);

   ////////////////////////////////////////////////////////////////////////
   // three-stage synchronisers; a change counts when stages two and three agree
   logic [2:0]  pin_in;
   logic [2:0]  lvl_r;
   logic [2:0]  lvl_nxt;
   assign pin_in = {i_ctl_sel_n, i_ctl_data, i_ctl_clk};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         logic [SYNC_STAGES-1:0] sync_r;
         always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               sync_r <= {SYNC_STAGES{1'b1}};
               lvl_r[g] <= 1'b1;
            end else begin
               sync_r <= {sync_r[SYNC_STAGES-2:0], pin_in[g]};
               lvl_r[g] <= lvl_nxt[g];
            end
         end
         assign lvl_nxt[g] = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // shift on control clock rise while selected, deliver on deselect
   logic              clk_rise;
   logic              sel_end;
   logic              selected;
   logic [CMD_W-1:0]  shift_r;
   logic [CNT_W-1:0]  count_r;
   logic              valid_r;

   assign clk_rise = lvl_nxt[0] && !lvl_r[0];
   assign sel_end  = lvl_nxt[2] && !lvl_r[2];
   assign selected = !lvl_r[2];

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_r <= '0;
         count_r <= '0;
         valid_r <= 1'b0;
      end else begin
         valid_r <= sel_end && (count_r == CMD_BITS);
         if (sel_end) begin
            count_r <= '0;
         end else if (selected && clk_rise) begin
            shift_r <= {shift_r[CMD_W-2:0], lvl_r[1]};
            if (count_r <= CMD_BITS) begin
               count_r <= count_r + 6'h01;
            end
         end
      end
   end

   assign cmd.valid = valid_r;
   assign cmd.word  = shift_r;

endmodule : tcw_ser_rx

// ### tcw_test_word.sv
// module: test control word of the down converter and its datapath hooks
// Operation
// - address 111 routes command into this word
// - update bit set transfers all pending registers
// - bit 13 forces input samples to 8000h
// - field 00 clears accumulator every fir cycle
// - field 01 disables the fir accumulator
// - field 10 accumulates continuously without clearing
// - bit 10 makes q pulse on rollover
// - bit 9 selects forced output pin levels
// - forced mode drives output clock from bit 8
// - forced mode drives word strobe from bit 7
// - forced mode drives i data from bit 6
// - forced mode drives q data from bit 5
// - bit 4 bypasses sine/cosine, coefficients 0.fffff
// - bit 3 bypasses scaling multiplier, factor one
// - bit 1 holds output until rams filled
// - bit 1 clear outputs immediately after reset
// - bit 0 disables overflow protection
// - test features only act while test enabled
// - address and update bits are not stored
// - bits 9 and 13 make outputs static
`timescale 1ns/1ps
module tcw_test_word
   import tcw_pkg::*;
(
   input  wire logic                 i_clock,
   input  wire logic                 i_arst_n,
   input  wire logic                 i_ctl_clk,
   input  wire logic                 i_ctl_data,
   input  wire logic                 i_ctl_sel_n,
   input  wire logic                 i_test_enable,
   input  wire logic                 i_dp_reset,
   input  wire logic                 i_ram_filled,
   input  wire logic [SAMPLE_W-1:0]  i_sample,
   input  wire logic                 i_fir_start,
   input  wire logic                 i_rollover,
   input  wire logic [COEF_W-1:0]    i_sin,
   input  wire logic [COEF_W-1:0]    i_cos,
   input  wire logic                 i_serial_output_clock,
   input  wire logic                 i_output_word_strobe,
   input  wire logic                 i_i_data,
   input  wire logic                 i_q_data,
   output logic                      o_update_all,
   output logic [SAMPLE_W-1:0]       o_sample,
   output logic                      o_acc_clear,
   output logic                      o_acc_enable,
   output logic [COEF_W-1:0]         o_sin,
   output logic [COEF_W-1:0]         o_cos,
   output logic                      o_scale_bypass,
   output logic                      o_ovf_protect,
   output logic                      o_output_enable,
   output logic                      o_outputs_static,
   output logic                      o_serial_output_clock,
   output logic                      o_output_word_strobe,
   output logic                      o_i_data,
   output logic                      o_q_data
);

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command reception and decode
   tcw_cmd_if cmd_bus ();

   tcw_ser_rx u_rx (
      .i_clock     (i_clock),
      .i_rst_n     (rst_n_r),
      .i_ctl_clk   (i_ctl_clk),
      .i_ctl_data  (i_ctl_data),
      .i_ctl_sel_n (i_ctl_sel_n),
      .cmd         (cmd_bus.rx)
   );

   logic               hit;
   logic               hit_update;
   logic [WORD_W-1:0]  hit_word;
   logic [WORD_W-1:0]  word_r;

   assign hit = cmd_bus.valid && (cmd_bus.word[ADDR_HI:ADDR_LO] == TEST_WORD_ADDR);
   assign hit_update = hit && cmd_bus.word[UPDATE_BIT];
   // only the low field is kept; address, update and reserved bits drop
   assign hit_word = cmd_bus.word[WORD_W-1:0];

   always_ff @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         word_r <= WORD_RST;
         o_update_all <= 1'b0;
      end else begin
         o_update_all <= hit_update;
         if (hit) begin
            word_r <= hit_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // effective test controls, gated by the test enable
   logic      t_force_data;
   logic      t_q_roll;
   logic      t_force_out;
   logic      t_sincos_byp;
   logic      t_scale_byp;
   logic      t_wait_ram;
   logic      t_ovf_dis;
   tcw_acc_t  acc_mode;

   assign t_force_data = i_test_enable && word_r[FORCE_DATA_BIT];
   assign t_q_roll     = i_test_enable && word_r[Q_ROLL_BIT];
   assign t_force_out  = i_test_enable && word_r[FORCE_OUT_BIT];
   assign t_sincos_byp = i_test_enable && word_r[SINCOS_BYP_BIT];
   assign t_scale_byp  = i_test_enable && word_r[SCALE_BYP_BIT];
   assign t_wait_ram   = i_test_enable && word_r[WAIT_RAM_BIT];
   assign t_ovf_dis    = i_test_enable && word_r[OVF_DIS_BIT];
   assign acc_mode = i_test_enable ? tcw_acc_t'(word_r[ACC_HI:ACC_LO]) : ACC_NORMAL;

   ////////////////////////////////////////////////////////////////////////
   // datapath steering
   logic [SAMPLE_W-1:0]  sample_nxt;
   logic                 acc_clear_nxt;
   logic                 acc_enable_nxt;
   logic [COEF_W-1:0]    sin_nxt;
   logic [COEF_W-1:0]    cos_nxt;

   assign sample_nxt = t_force_data ? FORCED_SAMPLE : i_sample;
   // reserved code behaves as normal accumulation
   assign acc_clear_nxt = i_fir_start &&
      ((acc_mode == ACC_NORMAL) || (acc_mode == ACC_RSV));
   assign acc_enable_nxt = (acc_mode != ACC_OFF);
   assign sin_nxt = t_sincos_byp ? UNITY_COEF : i_sin;
   assign cos_nxt = t_sincos_byp ? UNITY_COEF : i_cos;

   always_ff @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_sample <= '0;
         o_acc_clear <= 1'b0;
         o_acc_enable <= 1'b1;
         o_sin <= '0;
         o_cos <= '0;
         o_scale_bypass <= 1'b0;
         o_ovf_protect <= 1'b1;
      end else begin
         o_sample <= sample_nxt;
         o_acc_clear <= acc_clear_nxt;
         o_acc_enable <= acc_enable_nxt;
         o_sin <= sin_nxt;
         o_cos <= cos_nxt;
         o_scale_bypass <= t_scale_byp;
         o_ovf_protect <= !t_ovf_dis;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output gate: optional wait for data rams after a datapath reset
   tcw_gate_t gate_r;
   tcw_gate_t gate_nxt;

   always_comb begin
      gate_nxt = gate_r;
      unique case (gate_r)
         GATE_WAIT: begin
            if (!t_wait_ram || i_ram_filled) begin
               gate_nxt = GATE_RUN;
            end
         end
         GATE_RUN: begin
            gate_nxt = GATE_RUN;
         end
         default: begin
            gate_nxt = GATE_WAIT;
         end
      endcase
      if (i_dp_reset) begin
         gate_nxt = GATE_WAIT;
      end
   end

   always_ff @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         gate_r <= GATE_WAIT;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output pins: forced levels, rollover strobe on q, gating
   logic  run_nxt;
   logic  q_src;
   logic  clk_pin_nxt;
   logic  stb_pin_nxt;
   logic  i_pin_nxt;
   logic  q_pin_nxt;

   assign run_nxt = (gate_nxt == GATE_RUN);
   assign q_src = t_q_roll ? i_rollover : i_q_data;
   assign clk_pin_nxt = t_force_out ? word_r[F_CLK_BIT] :
                        (run_nxt && i_serial_output_clock);
   assign stb_pin_nxt = t_force_out ? word_r[F_STB_BIT] :
                        (run_nxt && i_output_word_strobe);
   assign i_pin_nxt = t_force_out ? word_r[F_I_BIT] : (run_nxt && i_i_data);
   assign q_pin_nxt = t_force_out ? word_r[F_Q_BIT] : (run_nxt && q_src);

   always_ff @(posedge i_clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_output_enable <= 1'b0;
         o_outputs_static <= 1'b0;
         o_serial_output_clock <= 1'b0;
         o_output_word_strobe <= 1'b0;
         o_i_data <= 1'b0;
         o_q_data <= 1'b0;
      end else begin
         o_output_enable <= run_nxt;
         o_outputs_static <= t_force_out && t_force_data;
         o_serial_output_clock <= clk_pin_nxt;
         o_output_word_strobe <= stb_pin_nxt;
         o_i_data <= i_pin_nxt;
         o_q_data <= q_pin_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!rst_n_r);

   load_word_a: assert property (
      hit |=> (word_r == $past(hit_word)))
      else $error("test word not loaded from addressed command");

   update_pulse_a: assert property (
      cmd_bus.valid |=> (o_update_all == $past(hit_update)))
      else $error("update pulse does not follow update bit");

   forced_sample_a: assert property (
      t_force_data |=> (o_sample == FORCED_SAMPLE))
      else $error("input sample not forced to midscale");

   acc_modes_a: assert property (
      (i_fir_start && (acc_mode != ACC_RSV)) |=>
      (o_acc_clear == ($past(acc_mode) == ACC_NORMAL)) &&
      (o_acc_enable == ($past(acc_mode) != ACC_OFF)))
      else $error("accumulator control mismatch");

   q_rollover_a: assert property (
      (t_q_roll && !t_force_out && run_nxt) |=> (o_q_data == $past(i_rollover)))
      else $error("q pin does not carry rollover");

   forced_pins_a: assert property (
      t_force_out |=> ({o_serial_output_clock, o_output_word_strobe, o_i_data, o_q_data}
                       == $past(word_r[F_CLK_BIT:F_Q_BIT])))
      else $error("forced pin levels wrong");

   unity_coef_a: assert property (
      t_sincos_byp |=> (o_sin == UNITY_COEF) && (o_cos == UNITY_COEF))
      else $error("sine/cosine bypass not applied");

   scale_bypass_a: assert property (
      o_scale_bypass == $past(t_scale_byp))
      else $error("scale bypass does not follow its bit");

   ovf_disable_a: assert property (
      o_ovf_protect == !$past(t_ovf_dis))
      else $error("overflow protection does not follow its bit");

   ram_wait_a: assert property (
      (i_dp_reset ##1 (t_wait_ram && !i_ram_filled && !i_dp_reset)) |=> !o_output_enable)
      else $error("output released before rams filled");

   no_wait_a: assert property (
      (i_dp_reset ##1 (!t_wait_ram && !i_dp_reset)) |=> o_output_enable)
      else $error("output not released after reset");

   gated_pins_a: assert property (
      (!run_nxt && !t_force_out) |=>
      !o_output_enable && !o_serial_output_clock && !o_output_word_strobe &&
      !o_i_data && !o_q_data)
      else $error("output pins not held while waiting for rams");

   test_off_a: assert property (
      !i_test_enable |=> (o_sample == $past(i_sample)) && o_ovf_protect && !o_outputs_static)
      else $error("test feature acted while disabled");

   // three cycles with an unchanged word: both pin samples come from forced levels
   static_mode_a: assert property (
      (t_force_out && t_force_data && $stable(word_r)) [*3] |->
      o_outputs_static &&
      $stable({o_serial_output_clock, o_output_word_strobe, o_i_data, o_q_data}))
      else $error("outputs not static");

endmodule : tcw_test_word

// ### tcw_loader.sv
// partner: serial control port of the loading processor, one command per frame
`timescale 1ns/1ps
module tcw_loader
   import tcw_pkg::*;
(
   input  wire logic  i_clock,
   output logic       o_ctl_clk,
   output logic       o_ctl_data,
   output logic       o_ctl_sel_n
);
   initial begin
      o_ctl_clk   = 1'b0;
      o_ctl_data  = 1'b0;
      o_ctl_sel_n = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge i_clock);
      #2;
   endtask : hold

   // clock stands low between frames; every phase lasts 5 clocks
   task automatic send(input logic [CMD_W-1:0] cmd, input int nbits);
      int b;
      hold(1);
      o_ctl_sel_n = 1'b0;
      for (b = CMD_W - 1; b >= CMD_W - nbits; b--) begin
         o_ctl_data = cmd[b];
         hold(5);
         o_ctl_clk = 1'b1;
         hold(5);
         o_ctl_clk = 1'b0;
         hold(5);
      end
      o_ctl_sel_n = 1'b1;
      // released data line shows the inverse of its last level
      o_ctl_data = ~o_ctl_data;
   endtask : send
endmodule : tcw_loader

// ### tcw_test_word_tb.sv
// testbench: test control word loaded serially, outputs checked against a model
`timescale 1ns/1ps
module tcw_test_word_tb;
   import tcw_pkg::*;
   logic                 i_clock = 1'b0;
   logic                 i_arst_n, i_test_enable, i_dp_reset, i_ram_filled;
   logic                 i_fir_start, i_rollover;
   logic [SAMPLE_W-1:0]  i_sample, o_sample;
   logic [COEF_W-1:0]    i_sin, i_cos, o_sin, o_cos;
   logic                 i_serial_output_clock, i_output_word_strobe, i_i_data, i_q_data;
   logic                 i_ctl_clk, i_ctl_data, i_ctl_sel_n;
   logic                 o_update_all, o_acc_clear, o_acc_enable, o_scale_bypass;
   logic                 o_ovf_protect, o_output_enable, o_outputs_static;
   logic                 o_serial_output_clock, o_output_word_strobe, o_i_data, o_q_data;
   logic [13:0]          word_m = 14'h0000;
   logic                 gate_m = 1'b1;
   logic                 pend = 1'b0;
   logic                 p1 = 1'b0;
   logic [15:0]          seed = 16'h002F;
   logic [65:0]          exp_q[$];
   int                   n_errors = 0;
   int                   tests_run = 0;
   int                   cyc = 0;
   logic [13:0]          tbl[8] = '{14'h2200, 14'h0018, 14'h0800, 14'h1000,
                                    14'h0400, 14'h0360, 14'h0290, 14'h0009};
   wire logic [65:0]     outs = {o_sample, o_acc_clear, o_acc_enable, o_sin, o_cos,
                                 o_scale_bypass, o_ovf_protect, o_output_enable,
                                 o_outputs_static, o_serial_output_clock,
                                 o_output_word_strobe, o_i_data, o_q_data};

   tcw_test_word tcw_test_word_i (.i_clock, .i_arst_n, .i_ctl_clk, .i_ctl_data,
      .i_ctl_sel_n, .i_test_enable, .i_dp_reset, .i_ram_filled, .i_sample, .i_fir_start,
      .i_rollover, .i_sin, .i_cos, .i_serial_output_clock, .i_output_word_strobe,
      .i_i_data, .i_q_data, .o_update_all, .o_sample, .o_acc_clear, .o_acc_enable,
      .o_sin, .o_cos, .o_scale_bypass, .o_ovf_protect, .o_output_enable,
      .o_outputs_static, .o_serial_output_clock, .o_output_word_strobe, .o_i_data,
      .o_q_data);

   tcw_loader tcw_loader_i (.i_clock, .o_ctl_clk(i_ctl_clk), .o_ctl_data(i_ctl_data),
      .o_ctl_sel_n(i_ctl_sel_n));

   always #25 i_clock = ~i_clock;

   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction : rnd

   // expected outputs from the current inputs and the loaded word
   function automatic logic [65:0] model();
      logic [13:0] w;
      logic [1:0]  m;
      logic [3:0]  pins;
      w = i_test_enable ? word_m : 14'h0000;
      m = w[12:11];
      pins = w[9] ? w[8:5] :
             (gate_m ? {i_serial_output_clock, i_output_word_strobe, i_i_data,
                        w[10] ? i_rollover : i_q_data} : 4'h0);
      return {w[13] ? FORCED_SAMPLE : i_sample,
              i_fir_start & (m == ACC_NORMAL | m == ACC_RSV),
              m != ACC_OFF,
              w[4] ? UNITY_COEF : i_sin, w[4] ? UNITY_COEF : i_cos,
              w[3], ~w[0], gate_m, w[9] & w[13], pins};
   endfunction : model

   task automatic check(input logic [65:0] seen, input logic [65:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("mismatches=%0d comparisons=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic idle();
      @(posedge i_clock);
      #2;
      pend = 1'b0;
   endtask : idle

   task automatic step(input logic note, input logic te);
      @(posedge i_clock);
      #2;
      i_test_enable = te;
      i_sample = rnd();
      i_sin = 20'({rnd(), rnd()});
      i_cos = 20'({rnd(), rnd()});
      {i_fir_start, i_rollover, i_serial_output_clock, i_output_word_strobe,
       i_i_data, i_q_data} = 6'(rnd());
      pend = note;
      if (note) exp_q.push_back(model());
   endtask : step

   task automatic load(input logic [CMD_W-1:0] cmd, input int nb, input logic exp);
      logic seen;
      int   k;
      seen = 1'b0;
      idle();
      tcw_loader_i.send(cmd, nb);
      for (k = 0; k < 12; k++) begin
         @(posedge i_clock);
         if (o_update_all === 1'b1) seen = 1'b1;
      end
      #2;
      check(66'(seen), 66'(exp));
   endtask : load

   always @(posedge i_clock) begin
      if (p1) check(outs, exp_q.pop_front());
      p1 <= pend;
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         wrap_up();
      end
   end

   initial begin
      int          k;
      logic [15:0] r;
      logic [13:0] w;
      {i_arst_n, i_test_enable, i_dp_reset, i_fir_start, i_rollover} = 5'h00;
      {i_serial_output_clock, i_output_word_strobe, i_i_data, i_q_data} = 4'h0;
      i_ram_filled = 1'b1;
      i_sample = 16'h0000;
      i_sin = 20'h00000;
      i_cos = 20'h00000;
      repeat (20) @(posedge i_clock);
      #2;
      i_arst_n = 1'b1;
      repeat (5) step(1'b0, 1'b0);
      repeat (4) step(1'b1, 1'b0);
      for (k = 0; k < 16; k++) begin
         r = rnd();
         w = (k < 8) ? tbl[k] : (r[13:0] & 14'h3FF9);
         if (w[12:11] == 2'h3) w[11] = 1'b0;
         load({TEST_WORD_ADDR, r[15], 22'h000000, w}, CMD_W, r[15]);
         word_m = w;
         repeat (4) step(1'b1, 1'b1);
         repeat (2) step(1'b1, 1'b0);
      end
      load({3'h6, 1'b1, 22'h000000, 14'h3FF9}, CMD_W, 1'b0);
      repeat (3) step(1'b1, 1'b1);
      load({TEST_WORD_ADDR, 1'b1, 22'h000000, 14'h2000}, CMD_W - 1, 1'b0);
      repeat (3) step(1'b1, 1'b1);
      load({TEST_WORD_ADDR, 1'b0, 22'h000000, 14'h0002}, CMD_W, 1'b0);
      word_m = 14'h0002;
      i_ram_filled = 1'b0;
      i_dp_reset = 1'b1;
      step(1'b0, 1'b1);
      i_dp_reset = 1'b0;
      gate_m = 1'b0;
      repeat (3) step(1'b0, 1'b1);
      repeat (4) step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      // the gate input moves together with an unchecked step, after the last checked step has been sampled
      i_ram_filled = 1'b1;
      repeat (2) step(1'b0, 1'b1);
      gate_m = 1'b1;
      repeat (3) step(1'b1, 1'b1);
      load({TEST_WORD_ADDR, 1'b0, 22'h000000, 14'h0000}, CMD_W, 1'b0);
      word_m = 14'h0000;
      i_dp_reset = 1'b1;
      step(1'b0, 1'b1);
      i_dp_reset = 1'b0;
      repeat (2) step(1'b0, 1'b1);
      repeat (3) step(1'b1, 1'b1);
      idle();
      repeat (3) @(posedge i_clock);
      wrap_up();
   end
endmodule : tcw_test_word_tb
